// ---- rpac_pkg.sv ----
/*
  rpac_pkg: register map, field positions, reset values, timing counts and
  shared types of the rtc power and alarm control block.
  assumes a 25 MHz core clock and a 32.768 kHz crystal level sampled by it.
*/
package rpac_pkg;

  // ************************************************
  // register map (8-bit registers, 5-bit address)
  // ************************************************
  localparam logic [4:0] ADR_DOW = 5'h06;
  localparam logic [4:0] ADR_STAT = 5'h07;
  localparam logic [4:0] ADR_CTRL = 5'h08;
  localparam logic [4:0] ADR_ATR = 5'h0a;
  localparam logic [4:0] ADR_DTR = 5'h0b;
  localparam logic [4:0] ADR_ALM0 = 5'h0c;
  localparam logic [4:0] ADR_ALM5 = 5'h11;
  localparam logic [6:0] TARGET_ID = 7'h6f;

  // status register bit positions
  localparam int ST_ACLR = 7;
  localparam int ST_SEAL = 5;
  localparam int ST_WREN = 4;
  localparam int ST_ALM = 2;
  localparam int ST_BAT = 1;
  localparam int ST_FAIL = 0;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ATR_RST = 8'h00;
  localparam logic [7:0] DTR_RST = 8'h80;
  localparam logic [7:0] TIME_RST = 8'h00;
  localparam logic [7:0] ALM_RST = 8'h00;

  // alarm compare masks, sec/min/hour/date/month/dow from low byte up
  localparam logic [47:0] AL_MASK = 48'h07_1f_3f_3f_7f_7f;

  // ************************************************
  // timing
  // ************************************************
  localparam int XTAL_HZ = 32768;
  localparam int PULSE_MS = 210;
  localparam int PULSE_TICKS = PULSE_MS * XTAL_HZ / 1000;
  localparam int PULSE_W = 13;
  localparam logic signed [9:0] TRIM_STEP = 10'sd3;
  localparam logic signed [9:0] TRIM_OFS = 10'sd63;
  localparam logic signed [9:0] TICK_PPM = 10'sd31;

  // ************************************************
  // types
  // ************************************************
  // comparator outputs: main vs backup +-50mV, main vs trip (+30mV on rise)
  typedef struct packed {
    logic main_gt_bat;
    logic main_lt_bat;
    logic main_lt_trip;
    logic main_gt_trip;
  } rpac_cmp_t;

  typedef struct packed {
    logic alarm_pulse_select;
    logic alarm_enable_bit;
    logic low_power_switch_select;
    logic backup_output_disable;
    logic second_interrupt_pin_en;
    logic pin1_function_select;
    logic [1:0] freq_out_select;
  } rpac_ctrl_t;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] dow;
  } rpac_time_t;

  typedef enum logic [2:0] {
    PWR_SEALED = 3'b001,
    PWR_MAIN = 3'b010,
    PWR_BACKUP = 3'b100
  } rpac_pwr_t;

endpackage : rpac_pkg

// ---- rpac_cal.sv ----
/*
  rpac_cal: bcd calendar counters with leap years, short months and
  12/24 hour format. assumes tick is a one-cycle 1 Hz enable and that
  wr is already qualified by the write-enable bit.
*/
module rpac_cal import rpac_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic wr,
  input wire logic [2:0] idx,
  input wire logic [7:0] wdata,
  output rpac_time_t now_q
);

  // ************************************************
  // helpers
  // ************************************************
  function automatic logic [7:0] bcd_next(input logic [7:0] v, input logic [7:0] last,
                                          input logic [7:0] first);
    if (v == last) bcd_next = first;
    else if (v[3:0] == 4'h9) bcd_next = {v[7:4] + 4'h1, 4'h0};
    else bcd_next = v + 8'h01;
  endfunction : bcd_next

  // years 00..99 map to 2000..2099, so every fourth year is a leap year
  function automatic logic [7:0] month_end(input logic [7:0] mo, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mo)
      8'h02: month_end = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
      default: month_end = 8'h31;
    endcase
  endfunction : month_end

  // ************************************************
  // carries
  // ************************************************
  logic [7:0] h24, h12, hr_d;
  logic sec_w, min_w, hr_w, dt_w, mo_w, day_roll;

  // bit7 picks 24 hour format, bit5 is pm in 12 hour format
  always_comb begin
    h24 = bcd_next({2'b00, now_q.hour[5:0]}, 8'h23, 8'h00);
    h12 = bcd_next({3'b000, now_q.hour[4:0]}, 8'h12, 8'h01);
    if (now_q.hour[7]) begin
      hr_d = {2'b10, h24[5:0]};
      day_roll = (now_q.hour[5:0] == 6'h23);
    end else begin
      hr_d = {2'b00, now_q.hour[5] ^ (now_q.hour[4:0] == 5'h11), h12[4:0]};
      day_roll = now_q.hour[5] && (now_q.hour[4:0] == 5'h11);
    end
  end

  assign sec_w = (now_q.sec == 8'h59);
  assign min_w = sec_w && (now_q.min == 8'h59);
  assign hr_w = min_w && day_roll;
  assign dt_w = hr_w && (now_q.date == month_end(now_q.month, now_q.year));
  assign mo_w = dt_w && (now_q.month == 8'h12);

  // a software write takes priority over the count in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      now_q <= {7{TIME_RST}};
    end else if (wr) begin
      case (idx)
        3'h0: now_q.sec <= wdata & 8'h7f;
        3'h1: now_q.min <= wdata & 8'h7f;
        3'h2: now_q.hour <= wdata & 8'hbf;
        3'h3: now_q.date <= wdata & 8'h3f;
        3'h4: now_q.month <= wdata & 8'h1f;
        3'h5: now_q.year <= wdata;
        default: now_q.dow <= wdata & 8'h07;
      endcase
    end else if (tick) begin
      now_q.sec <= bcd_next(now_q.sec, 8'h59, 8'h00);
      if (sec_w) now_q.min <= bcd_next(now_q.min, 8'h59, 8'h00);
      if (min_w) now_q.hour <= hr_d;
      if (hr_w) begin
        now_q.date <= bcd_next(now_q.date, month_end(now_q.month, now_q.year), 8'h01);
        now_q.dow <= bcd_next(now_q.dow, 8'h06, 8'h00);
      end
      if (dt_w) now_q.month <= bcd_next(now_q.month, 8'h12, 8'h01);
      if (mo_w) now_q.year <= bcd_next(now_q.year, 8'h99, 8'h00);
    end
  end

endmodule : rpac_cal

// ---- rpac_top.sv ----
/*
  rpac_top: supply selection with battery seal, clock start gate and
  failure flag, digital trim, alarm in single and pulsed modes, frequency
  output and the register port. assumes comparator levels and the crystal
  level arrive asynchronously; register port strobes are on CORE_CLK.
*/
module rpac_top import rpac_pkg::*; #(
  parameter int PULSE_LEN = PULSE_TICKS
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic XTAL_IN,
  input rpac_cmp_t CMP_IN,
  input wire logic [6:0] REG_TGT,
  input wire logic [4:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic IRQ1_O,
  output logic IRQ1_OE,
  output logic SECOND_INTERRUPT_PIN_O,
  output logic SECOND_INTERRUPT_PIN_OE,
  output logic BAT_SWITCH,
  output logic SERIAL_EN,
  output logic [7:0] ANALOG_TRIM
);

  // ************************************************
  // input synchronisers
  // ************************************************
  logic [4:0] raw_in, meta_q, sync_q;
  logic xtal_prev_q, xtick;
  rpac_cmp_t cmp;

  assign raw_in = {XTAL_IN, CMP_IN};

  // two flops per pin; only the second is ever looked at
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= raw_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  assign cmp = rpac_cmp_t'(sync_q[3:0]);

  // crystal rising edge gives the 32.768 kHz enable
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) xtal_prev_q <= 1'b0;
    else xtal_prev_q <= sync_q[4];
  end
  assign xtick = sync_q[4] & ~xtal_prev_q;

  // ************************************************
  // register state and decode
  // ************************************************
  rpac_ctrl_t ctrl_q;
  rpac_pwr_t pwr_q;
  rpac_time_t now;
  logic [7:0] atr_q, dtr_q, rd_mux;
  logic [7:0] alarm_q [6];
  logic aclr_q, seal_q, wren_q, alm_q, fail_q, run_q;
  logic hit, wr_ok, rd_ok, t_wr, stat_wr, stat_rd, out_off;
  logic [2:0] al_idx;

  function automatic logic is_time(input logic [4:0] a);
    is_time = (a <= ADR_DOW);
  endfunction : is_time

  function automatic logic is_alarm(input logic [4:0] a);
    is_alarm = (a >= ADR_ALM0) && (a <= ADR_ALM5);
  endfunction : is_alarm

  // the port is dead off main supply, so nothing is taken there
  assign hit = (REG_TGT == TARGET_ID) && (pwr_q == PWR_MAIN);
  assign wr_ok = REG_WR & hit;
  assign rd_ok = REG_RD & hit;
  assign t_wr = wr_ok & is_time(REG_ADDR) & wren_q;
  assign stat_wr = wr_ok & (REG_ADDR == ADR_STAT);
  assign stat_rd = rd_ok & (REG_ADDR == ADR_STAT);
  assign al_idx = 3'(REG_ADDR - ADR_ALM0);
  assign out_off = (pwr_q == PWR_BACKUP) & ctrl_q.backup_output_disable;

  // plain control and trim registers
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= rpac_ctrl_t'(CTRL_RST);
      atr_q <= ATR_RST;
      dtr_q <= DTR_RST;
      aclr_q <= 1'b0;
      wren_q <= 1'b0;
    end else if (wr_ok) begin
      if (REG_ADDR == ADR_CTRL) ctrl_q <= rpac_ctrl_t'(REG_WDATA);
      if (REG_ADDR == ADR_ATR) atr_q <= REG_WDATA;
      if (REG_ADDR == ADR_DTR) dtr_q <= REG_WDATA;
      if (stat_wr) begin
        aclr_q <= REG_WDATA[ST_ACLR];
        wren_q <= REG_WDATA[ST_WREN];
      end
    end
  end

  // alarm compare registers; other unused addresses simply drop writes
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 6; i++) alarm_q[i] <= ALM_RST;
    end else if (wr_ok && is_alarm(REG_ADDR)) begin
      alarm_q[al_idx] <= REG_WDATA;
    end
  end

  // ************************************************
  // supply selection and battery seal
  // ************************************************
  logic go_main, go_bat;

  assign go_main = cmp.main_gt_bat | cmp.main_gt_trip;
  // low power mode drops the trip check, leaving the battery compare alone to decide
  assign go_bat = cmp.main_lt_bat & (ctrl_q.low_power_switch_select | cmp.main_lt_trip);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pwr_q <= PWR_SEALED;
    end else begin
      case (pwr_q)
        PWR_SEALED: if (go_main) pwr_q <= PWR_MAIN;
        PWR_MAIN: if (go_bat) pwr_q <= seal_q ? PWR_SEALED : PWR_BACKUP;
        PWR_BACKUP: if (go_main) pwr_q <= PWR_MAIN;
        default: pwr_q <= PWR_SEALED;
      endcase
    end
  end

  // seal is spent on first main power; a re-arm in that cycle still wins
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) seal_q <= 1'b1;
    else if (stat_wr && REG_WDATA[ST_SEAL]) seal_q <= 1'b1;
    else if (pwr_q == PWR_SEALED && go_main) seal_q <= 1'b0;
  end

  // reset stands for the loss of both supplies
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      fail_q <= 1'b1;
      run_q <= 1'b0;
    end else if (t_wr) begin
      fail_q <= 1'b0;
      run_q <= 1'b1;
    end
  end

  // ************************************************
  // trimmed one second time base
  // ************************************************
  logic [15:0] presc_q, sec_end;
  logic signed [9:0] acc_q, acc_sum, trim_ppm;
  logic short_q, long_q, sec_tick, tick_dly_q;

  // code 0..63 maps to -63..+126 ppm; one crystal tick is about 31 ppm
  assign trim_ppm = $signed({4'h0, dtr_q[5:0]}) * TRIM_STEP - TRIM_OFS;
  assign acc_sum = acc_q + trim_ppm;
  assign sec_end = 16'(XTAL_HZ - 1) - {15'h0, short_q} + {15'h0, long_q};
  // keeps counting on backup; only a frozen clock stops it
  assign sec_tick = run_q & xtick & (presc_q == sec_end);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      presc_q <= 16'h0000;
    end else if (sec_tick) begin
      presc_q <= 16'h0000;
    end else if (run_q && xtick) begin
      presc_q <= presc_q + 16'h0001;
    end
  end

  // positive error shortens a second by one tick, negative stretches it
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      acc_q <= 10'sd0;
      short_q <= 1'b0;
      long_q <= 1'b0;
    end else if (sec_tick) begin
      short_q <= (acc_sum >= TICK_PPM);
      long_q <= (acc_sum <= -TICK_PPM);
      if (acc_sum >= TICK_PPM) acc_q <= acc_sum - TICK_PPM;
      else if (acc_sum <= -TICK_PPM) acc_q <= acc_sum + TICK_PPM;
      else acc_q <= acc_sum;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) tick_dly_q <= 1'b0;
    else tick_dly_q <= sec_tick;
  end

  rpac_cal u_cal (
    .clk(CORE_CLK),
    .rst(RST),
    .tick(sec_tick),
    .wr(t_wr),
    .idx(REG_ADDR[2:0]),
    .wdata(REG_WDATA),
    .now_q(now)
  );

  // ************************************************
  // alarm
  // ************************************************
  logic [7:0] tbyte [6];
  logic a_match, a_any, match_prev_q, alarm_on, alarm_hit, irq_act;
  logic [PULSE_W-1:0] pulse_q;

  assign tbyte[0] = now.sec;
  assign tbyte[1] = now.min;
  assign tbyte[2] = now.hour;
  assign tbyte[3] = now.date;
  assign tbyte[4] = now.month;
  assign tbyte[5] = now.dow;

  // every enabled field must agree; bit7 of each alarm byte enables it
  always_comb begin
    a_match = 1'b1;
    a_any = 1'b0;
    for (int i = 0; i < 6; i++) begin
      if (alarm_q[i][7] && ((alarm_q[i] & AL_MASK[i*8 +: 8]) != (tbyte[i] & AL_MASK[i*8 +: 8])))
        a_match = 1'b0;
      a_any = a_any | alarm_q[i][7];
    end
  end

  // pin 1 in clock mode means the alarm is off
  assign alarm_on = ctrl_q.alarm_enable_bit & ctrl_q.pin1_function_select & ~out_off;
  // only a fresh match counts, so a coarse alarm fires once per period
  assign alarm_hit = tick_dly_q & alarm_on & a_any & a_match & ~match_prev_q;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) match_prev_q <= 1'b0;
    else if (tick_dly_q) match_prev_q <= a_any & a_match;
  end

  // a new match beats a clear in the same cycle
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) alm_q <= 1'b0;
    else if (alarm_hit) alm_q <= 1'b1;
    else if (stat_wr && !REG_WDATA[ST_ALM]) alm_q <= 1'b0;
    else if (stat_rd && aclr_q) alm_q <= 1'b0;
  end

  // counted in crystal ticks so bus traffic cannot stretch it
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) pulse_q <= '0;
    else if (alarm_hit && ctrl_q.alarm_pulse_select) pulse_q <= PULSE_W'(PULSE_LEN);
    else if (xtick && pulse_q != '0) pulse_q <= pulse_q - 1'b1;
  end

  assign irq_act = ~out_off & (ctrl_q.alarm_pulse_select ? (pulse_q != '0) : alm_q);

  // ************************************************
  // frequency output and pins
  // ************************************************
  logic [4:0] fdiv_q;
  logic fout_lvl;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) fdiv_q <= 5'h00;
    else if (xtick) fdiv_q <= fdiv_q + 5'h01;
  end

  // 32768, 8192, 4096 and 1024 Hz
  always_comb begin
    case (ctrl_q.freq_out_select)
      2'h0: fout_lvl = sync_q[4];
      2'h1: fout_lvl = fdiv_q[1];
      2'h2: fout_lvl = fdiv_q[2];
      default: fout_lvl = fdiv_q[4];
    endcase
  end

  // open drain: enable high pulls the pin low
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      IRQ1_OE <= 1'b0;
      SECOND_INTERRUPT_PIN_OE <= 1'b0;
      IRQ1_O <= 1'b0;
      SECOND_INTERRUPT_PIN_O <= 1'b0;
    end else begin
      IRQ1_OE <= ctrl_q.pin1_function_select ? irq_act : (~out_off & ~fout_lvl);
      SECOND_INTERRUPT_PIN_OE <= ctrl_q.second_interrupt_pin_en & irq_act;
      IRQ1_O <= 1'b0;
      SECOND_INTERRUPT_PIN_O <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      BAT_SWITCH <= 1'b0;
      SERIAL_EN <= 1'b0;
      ANALOG_TRIM <= ATR_RST;
    end else begin
      BAT_SWITCH <= (pwr_q == PWR_BACKUP);
      SERIAL_EN <= (pwr_q == PWR_MAIN);
      ANALOG_TRIM <= atr_q;
    end
  end

  // ************************************************
  // read path
  // ************************************************
  always_comb begin
    rd_mux = 8'h00;
    if (is_time(REG_ADDR)) rd_mux = tbyte[0];
    case (REG_ADDR)
      5'h01: rd_mux = now.min;
      5'h02: rd_mux = now.hour;
      5'h03: rd_mux = now.date;
      5'h04: rd_mux = now.month;
      5'h05: rd_mux = now.year;
      ADR_DOW: rd_mux = now.dow;
      ADR_STAT: rd_mux = {aclr_q, 1'b0, seal_q, wren_q, 1'b0, alm_q,
                          pwr_q == PWR_BACKUP, fail_q};
      ADR_CTRL: rd_mux = ctrl_q;
      ADR_ATR: rd_mux = atr_q;
      ADR_DTR: rd_mux = dtr_q;
      default: if (is_alarm(REG_ADDR)) rd_mux = alarm_q[al_idx];
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) REG_RDATA <= 8'h00;
    else REG_RDATA <= rd_ok ? rd_mux : 8'h00;
  end

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  property p_bus_off;
    (pwr_q != PWR_MAIN) && REG_RD |=> REG_RDATA == 8'h00;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("read answered off main");

  property p_return;
    pwr_q == PWR_BACKUP && go_main |=> pwr_q == PWR_MAIN ##1 !BAT_SWITCH;
  endproperty
  a_return: assert property (p_return) else $error("no return to main");

  property p_lp;
    pwr_q == PWR_MAIN && ctrl_q.low_power_switch_select && cmp.main_lt_bat && !seal_q
      |=> pwr_q == PWR_BACKUP ##1 BAT_SWITCH;
  endproperty
  a_lp: assert property (p_lp) else $error("low power switch missed");

  property p_trip;
    pwr_q == PWR_MAIN && !ctrl_q.low_power_switch_select && !cmp.main_lt_trip
      |=> pwr_q == PWR_MAIN;
  endproperty
  a_trip: assert property (p_trip) else $error("left main above trip");

  property p_seal;
    pwr_q == PWR_MAIN && seal_q && go_bat |=> pwr_q == PWR_SEALED ##1 !BAT_SWITCH;
  endproperty
  a_seal: assert property (p_seal) else $error("sealed part drew battery");

  property p_freeze;
    !run_q |-> !sec_tick;
  endproperty
  a_freeze: assert property (p_freeze) else $error("clock ran before set");

  property p_wren;
    wr_ok && is_time(REG_ADDR) && !wren_q && !sec_tick |=> now == $past(now);
  endproperty
  a_wren: assert property (p_wren) else $error("locked time changed");

  property p_flag;
    alarm_hit |=> alm_q;
  endproperty
  a_flag: assert property (p_flag) else $error("alarm flag not set");

  property p_pulse;
    alarm_hit && ctrl_q.alarm_pulse_select |=> pulse_q == PULSE_W'(PULSE_LEN);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse length wrong");

  property p_fo_blocks;
    !ctrl_q.pin1_function_select |-> !alarm_hit;
  endproperty
  a_fo_blocks: assert property (p_fo_blocks) else $error("alarm in clock mode");

  property p_aclr;
    stat_rd && aclr_q && !alarm_hit |=> !alm_q;
  endproperty
  a_aclr: assert property (p_aclr) else $error("auto clear failed");

  property p_cv_backup;
    pwr_q == PWR_MAIN ##1 pwr_q == PWR_BACKUP;
  endproperty
  c_cv_backup: cover property (p_cv_backup);

  property p_cv_battery_seal_rearm;
    pwr_q == PWR_MAIN ##1 pwr_q == PWR_SEALED;
  endproperty
  c_cv_battery_seal_rearm: cover property (p_cv_battery_seal_rearm);

  property p_cv_pulse;
    alarm_hit && ctrl_q.alarm_pulse_select;
  endproperty
  c_cv_pulse: cover property (p_cv_pulse);

endmodule : rpac_top

// ---- rpac_xtal_src.sv ----
/*
  rpac_xtal_src: crystal source that feeds the block's time base.
  assumes the bench wants a free running 320 ns square wave.
*/
module rpac_xtal_src (
  output logic xtal
);
  timeunit 1ns;
  timeprecision 1ps;
  // **********************************
  // oscillator
  // **********************************
  // a crystal never stops between frames, so it runs free
  initial xtal = 1'b0;
  always #160 xtal = ~xtal;
endmodule : rpac_xtal_src

// ---- rpac_top_test.sv ----
/*
  rpac_top_test: register port tests of supply switching, seal, write
  protect and unused space. assumes rpac_pkg and rpac_top are compiled.
*/
module rpac_top_test import rpac_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // **********************************
  // signals and helpers
  // **********************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic xtal;
  rpac_cmp_t cmp = 4'h0;
  logic [6:0] tgt = 7'h00;
  logic [4:0] adr = 5'h00;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdat;
  logic ser_en;
  logic bat_sw;
  logic [7:0] atrim;
  logic irq1_o;
  logic irq1_oe;
  logic second_interrupt_pin_o;
  logic second_interrupt_pin_oe;
  int oe_cnt = 0;
  int fail_count = 0;
  int n_checks = 0;
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
  always #20 clk = ~clk;
  rpac_xtal_src u_rpac_xtal_src (.xtal(xtal));
  // short pulse length keeps alarm timing within a short run
  rpac_top #(.PULSE_LEN(4)) u_rpac_top (
    .CORE_CLK(clk), .RST(rst), .XTAL_IN(xtal), .CMP_IN(cmp), .REG_TGT(tgt),
    .REG_ADDR(adr), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat),
    .IRQ1_O(irq1_o), .IRQ1_OE(irq1_oe), .SECOND_INTERRUPT_PIN_O(second_interrupt_pin_o), .SECOND_INTERRUPT_PIN_OE(second_interrupt_pin_oe), .BAT_SWITCH(bat_sw),
    .SERIAL_EN(ser_en), .ANALOG_TRIM(atrim));
  task automatic stop_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  // one-cycle write strobe, released on the next edge
  task automatic wr_reg(input logic [6:0] t, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    tgt <= t;
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [6:0] t, input logic [4:0] a, input logic [7:0] e,
                        input logic [7:0] m);
    @(posedge clk);
    tgt <= t;
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdat & m, e)
  endtask : rd_reg
  // bounded wait for the port to open or close, then let the flag settle
  task automatic wait_port(input logic v);
    int i;
    // look clear of the edge so the flag is never read as it launches
    for (i = 0; i < 40 && ser_en !== v; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK(ser_en, v)
    if (ser_en !== v) stop_test();
    repeat (3) @(posedge clk);
  endtask : wait_port
  // counts cycles with pin 1 pulled low; an unknown counts as pulled low
  task automatic count_oe(input int n, output int c);
    c = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      if (irq1_oe !== 1'b0) c++;
    end
  endtask : count_oe
  // **********************************
  // main sequence
  // **********************************
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(bat_sw, 1'b0)
    `CHK(second_interrupt_pin_oe, 1'b0)
    rd_reg(7'h6f, ADR_STAT, 8'h00, 8'hff);
    cmp <= 4'b1001;
    wait_port(1'b1);
    rd_reg(7'h6f, ADR_STAT, 8'h01, 8'h01);
    // reset control puts the crystal itself on pin 1: half of all cycles low
    count_oe(64, oe_cnt);
    `CHK(oe_cnt, 32)
    wr_reg(7'h6f, 5'h00, 8'h05);
    rd_reg(7'h6f, 5'h00, 8'h00, 8'hff);
    wr_reg(7'h6f, ADR_STAT, 8'h10);
    wr_reg(7'h6f, 5'h00, 8'h05);
    rd_reg(7'h6f, 5'h00, 8'h05, 8'h7f);
    rd_reg(7'h6f, ADR_STAT, 8'h00, 8'h01);
    wr_reg(7'h6f, 5'h16, 8'hff);
    rd_reg(7'h6f, 5'h16, 8'h00, 8'hff);
    rd_reg(7'h6e, 5'h00, 8'h00, 8'hff);
    wr_reg(7'h6f, ADR_ATR, 8'h2a);
    // the trim copy is registered, so it shows one edge after the write
    @(posedge clk);
    #1;
    `CHK(atrim, 8'h2a)
    cmp <= 4'b0110;
    wait_port(1'b0);
    `CHK(bat_sw, 1'b1)
    count_oe(64, oe_cnt);
    `CHK(oe_cnt, 32)
    rd_reg(7'h6f, ADR_ATR, 8'h00, 8'hff);
    cmp <= 4'b0001;
    wait_port(1'b1);
    `CHK(bat_sw, 1'b0)
    rd_reg(7'h6f, ADR_ATR, 8'h2a, 8'hff);
    // low power switching, with the pin output silenced on backup
    wr_reg(7'h6f, ADR_CTRL, 8'h30);
    // main under backup but between trip and trip plus margin: no way back
    cmp <= 4'b0100;
    wait_port(1'b0);
    count_oe(64, oe_cnt);
    `CHK(oe_cnt, 0)
    cmp <= 4'b1000;
    wait_port(1'b1);
    // slowest clock: 128 cycles low in every 256
    wr_reg(7'h6f, ADR_CTRL, 8'h03);
    count_oe(256, oe_cnt);
    `CHK(oe_cnt, 128)
    wr_reg(7'h6f, ADR_CTRL, 8'h04);
    count_oe(64, oe_cnt);
    `CHK(oe_cnt, 0)
    `CHK({irq1_o, second_interrupt_pin_o, second_interrupt_pin_oe}, 3'b000)
    wr_reg(7'h6f, ADR_CTRL, 8'h00);
    cmp <= 4'b0101;
    repeat (10) @(posedge clk);
    `CHK(ser_en, 1'b1)
    cmp <= 4'b1001;
    wr_reg(7'h6f, ADR_STAT, 8'h20);
    cmp <= 4'b0110;
    wait_port(1'b0);
    `CHK(bat_sw, 1'b0)
    cmp <= 4'b1001;
    wait_port(1'b1);
    stop_test();
  end
endmodule : rpac_top_test
